// ==== adc_clock_and_output_formatter_tb_top.sv ====
`timescale 1ns/1ps
module adc_clock_and_output_formatter_tb_top
    import adcfmt_pkg::*;
;
    logic         i_clk, i_reset, i_wr, i_rd, encode_clock, enc_run, psel, mstrap;
    logic [6:0]   i_addr;
    logic [7:0]   i_wdata, o_rdata, o_drive_current, o_lvds_data_pair;
    adcfmt_word_t i_sample, o_cmos_word, cmos_got, ddr_got;
    logic         o_enc_term_en, o_stab_en, o_locked, o_ka_active, o_internal_clk;
    logic         o_ddr_mode, o_out_term_en, clk_p, clk_n, o_lvds_ovf, o_lvds_clk;
    int           n_errors, checked, cycles;

    adcfmt_top i_adcfmt_top (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_encode_clock(encode_clock), .i_prog_sel_strap(psel),
        .i_mode_strap(mstrap), .i_sample(i_sample), .o_enc_term_en(o_enc_term_en),
        .o_stab_en(o_stab_en), .o_locked(o_locked), .o_ka_active(o_ka_active),
        .o_internal_clk(o_internal_clk), .o_ddr_mode(o_ddr_mode),
        .o_out_term_en(o_out_term_en), .o_drive_current(o_drive_current),
        .o_cmos_word(o_cmos_word), .o_output_data_clock_p(clk_p),
        .o_output_data_clock_n(clk_n), .o_lvds_data_pair(o_lvds_data_pair),
        .o_lvds_ovf(o_lvds_ovf), .o_lvds_clk(o_lvds_clk));

    adcfmt_rx_model i_adcfmt_rx_model (.i_clk(i_clk), .i_reset(i_reset),
        .i_cmos_word(o_cmos_word), .i_clk_p(clk_p), .i_pair(o_lvds_data_pair),
        .i_ovf(o_lvds_ovf), .i_lvds_clk(o_lvds_clk), .o_cmos_got(cmos_got),
        .o_ddr_got(ddr_got));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // encode source: 80 ns, even duty, free phase; stands low when stopped
    initial begin
        encode_clock = 1'b0;
        #3;
        forever #40 encode_clock = enc_run ? ~encode_clock : 1'b0;
    end
    // hang guard, well above the expected run length
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic check(string what, logic [16:0] seen, logic [16:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [6:0] a, logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic rd(logic [6:0] a, logic [7:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 check("rdata", o_rdata, exp);
    endtask
    task automatic wait_cyc(int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic t_reset_values();
        check("drive", o_drive_current, 8'h46);
        check("stab", o_stab_en, 1'b0);
        check("eterm", o_enc_term_en, 1'b0);
        rd(7'h03, 8'h00);
    endtask
    task automatic t_regs();
        wr(7'h03, 8'h20);
        #1 check("eterm", o_enc_term_en, 1'b1);
        rd(7'h03, 8'h20);
        wait_cyc(1);
        check("rdata idle", o_rdata, 8'h00);
        rd(7'h10, 8'h00);
        rd(7'h03, 8'h20);
        wr(7'h03, 8'h00);
        #1 check("eterm off", o_enc_term_en, 1'b0);
    endtask
    task automatic t_current();
        logic [7:0] tbl [8] = '{8'h46, 8'h50, 8'h5A, 8'h46, 8'h3C, 8'h32, 8'h2A, 8'h23};
        for (int c = 0; c < 8; c++) begin
            wr(7'h04, 8'(c << 4));
            #1 check("drive", o_drive_current, tbl[c]);
        end
        wr(7'h04, 8'h08);
        #1 check("oterm", o_out_term_en, 1'b1);
        check("drive x2", o_drive_current, 8'h8C);
        wr(7'h04, 8'h00);
    endtask
    task automatic t_stream(logic ddr);
        adcfmt_word_t v [3] = '{17'h0_8000, 17'h0_FFFF, 17'h1_0000};
        for (int f = 0; f < 2; f++) begin
            wr(7'h05, 8'(f));
            for (int i = 0; i < 3; i++) begin
                @(posedge i_clk);
                i_sample <= v[i];
                wait_cyc(80);
                check("clk n", clk_n, ddr ? 1'b0 : !clk_p);
                if (ddr) check("ddr", ddr_got, v[i] ^ (17'(f) << 15));
                else check("cmos", cmos_got, v[i] ^ (17'(f) << 15));
            end
        end
        if (ddr) check("cmos idle", o_cmos_word, 17'h0_0000);
    endtask
    task automatic t_strap();
        wr(7'h04, 8'h01);
        #1 check("mode", o_ddr_mode, 1'b1);
        t_stream(1'b1);
        psel <= 1'b1;
        mstrap <= 1'b0;
        wait_cyc(6);
        check("strap low", o_ddr_mode, 1'b0);
        mstrap <= 1'b1;
        wait_cyc(6);
        check("strap high", o_ddr_mode, 1'b1);
        psel <= 1'b0;
        wr(7'h04, 8'h00);
        #1 check("mode", o_ddr_mode, 1'b0);
    endtask
    task automatic t_keepalive(logic off);
        int toggles;
        logic last;
        wr(7'h03, {3'h0, off, 4'h0});
        enc_run = 1'b0;
        wait_cyc(260);
        check("ka", o_ka_active, !off);
        toggles = 0;
        last = o_internal_clk;
        repeat (300) begin
            @(posedge i_clk);
            #1 toggles += (o_internal_clk !== last);
            last = o_internal_clk;
        end
        check("ka runs", toggles >= 4, !off);
        enc_run = 1'b1;
        wr(7'h03, 8'h00);
    endtask
    task automatic t_lock();
        int n;
        wr(7'h03, 8'h01);
        #1 check("stab", o_stab_en, 1'b1);
        wait_cyc(400);
        check("early lock", o_locked, 1'b0);
        n = 0;
        while (o_locked !== 1'b1 && n < 1600) begin
            wait_cyc(1);
            n++;
        end
        check("locked", o_locked, 1'b1);
        wr(7'h00, 8'h80);
        rd(7'h03, 8'h00);
        rd(7'h00, 8'h00);
        check("stab off", o_stab_en, 1'b0);
    endtask

    task automatic tally_and_finish();
        $display("errors %0d checked %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // full-rate runs at 12.5 Msps only, overrange held from the last DDR stream sample to the end
    initial begin
        {i_reset, i_wr, i_rd, psel, mstrap, enc_run} = 6'b100000;
        {i_addr, i_wdata, i_sample} = '0;
        {n_errors, checked, cycles} = '0;
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        enc_run = 1'b1;
        wait_cyc(2);
        t_reset_values();
        t_regs();
        t_current();
        t_stream(1'b0);
        t_strap();
        t_keepalive(1'b0);
        t_keepalive(1'b1);
        t_lock();
        tally_and_finish();
    end
endmodule

// ==== adcfmt_pkg.sv ====
package adcfmt_pkg;
    // sample word travels with its overflow bit
    typedef struct packed {
        logic        ovf;
        logic [15:0] data;
    } adcfmt_word_t;
    typedef enum logic [1:0] {ST_ABSENT, ST_ACQUIRE, ST_LOCKED} adcfmt_lock_t;
endpackage

// ==== adcfmt_regs.svh ====
`ifndef ADCFMT_REGS_SVH
`define ADCFMT_REGS_SVH
// Overview of operation
// - clock register bit 5 high switches on the encode input termination
// - duty stabilizer off by default; clock register bit 0 enables it, serial only
// - stabilizer accepts 30 to 70 percent duty, makes a 50 percent internal clock
// - stabilizer needs about one hundred encode edges to lock after a change
// - with no encode clock an on-chip 800 kHz keep-alive clock runs
// - clock register bit 4 high stops the keep-alive clock
// - output mode comes from output register bit 0, or strap in parallel mode
// - full-rate mode: 16 bits, overflow, clock; data changes on clock fall
// - DDR mode: two bits on each of eight pairs, overflow and clock separate
// - DDR mode: data changes on both clock edges
// - driver current defaults to 3.5 mA, selectable from 1.75 to 4.5 mA
// - output register bit 3 enables output termination and doubles current
// - overflow high out of range, same latency as its data
// - clock register bits 2..1 delay output clock 0/45/90/135 degrees, stabilizer on
// - clock register bit 0 also inverts output clock polarity
// - offset binary by default; format register bit 0 selects two's complement
// - zero maps to mid code, full scale to extreme codes
// - parallel mode strap low selects full-rate, high selects DDR
// - transfer carries read flag, seven-bit address, eight data; reads change nothing
// - software reset clears every configuration bit to zero
`define ADCFMT_REG_RESET   7'h00
`define ADCFMT_REG_CLOCK   7'h03
`define ADCFMT_REG_OUTPUT  7'h04
`define ADCFMT_REG_FORMAT  7'h05
`define ADCFMT_SWRST_BIT   7
`define ADCFMT_STAB_BIT    0
`define ADCFMT_PHASE_LSB   1
`define ADCFMT_KA_OFF_BIT  4
`define ADCFMT_ETERM_BIT   5
`define ADCFMT_DDR_BIT     0
`define ADCFMT_OTERM_BIT   3
`define ADCFMT_DRV_LSB     4
`define ADCFMT_TWOS_BIT    0
`define ADCFMT_CFG_RESET   8'h00
`define ADCFMT_CLK_NS      10
`define ADCFMT_KA_HALF_NS  625
`define ADCFMT_KA_HALF_CYC (`ADCFMT_KA_HALF_NS / `ADCFMT_CLK_NS)
`define ADCFMT_LOST_NS     2000
`define ADCFMT_LOST_CYC    (`ADCFMT_LOST_NS / `ADCFMT_CLK_NS)
`define ADCFMT_LOCK_EDGES  100
`endif

// ==== adcfmt_rx_model.sv ====
`timescale 1ns/1ps
module adcfmt_rx_model
    import adcfmt_pkg::*;
(
    input  logic         i_clk,
    input  logic         i_reset,
    input  adcfmt_word_t i_cmos_word,
    input  logic         i_clk_p,
    input  logic [7:0]   i_pair,
    input  logic         i_ovf,
    input  logic         i_lvds_clk,
    output adcfmt_word_t o_cmos_got,
    output adcfmt_word_t o_ddr_got
);
    logic       p_q;
    logic       l_q;
    logic       ovf_q;
    logic [7:0] even_q;
    logic [7:0] odd_q;

    // interleave the two phases back into one word
    function automatic logic [15:0] weave(input logic [7:0] e, input logic [7:0] o);
        logic [15:0] w;
        for (int k = 0; k < 8; k++) begin
            w[2*k]   = e[k];
            w[2*k+1] = o[k];
        end
        return w;
    endfunction

    // full-rate capture on clock rise; data has been steady since the fall
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            p_q        <= 1'b0;
            o_cmos_got <= '0;
        end else begin
            p_q <= i_clk_p;
            if (!p_q && i_clk_p) o_cmos_got <= i_cmos_word;
        end
    end

    // ddr: low phase holds even bits, high phase odd bits; word closes at fall
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            l_q       <= 1'b0;
            ovf_q     <= 1'b0;
            even_q    <= '0;
            odd_q     <= '0;
            o_ddr_got <= '0;
        end else begin
            l_q <= i_lvds_clk;
            if (!i_lvds_clk) begin
                even_q <= i_pair;
                ovf_q  <= i_ovf;
            end else begin
                odd_q <= i_pair;
            end
            if (l_q && !i_lvds_clk) o_ddr_got <= {ovf_q, weave(even_q, odd_q)};
        end
    end
endmodule

// ==== adcfmt_top.sv ====
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "adcfmt_regs.svh"
module adcfmt_top
    import adcfmt_pkg::*;
(
    input  logic         i_clk,
    input  logic         i_reset,
    input  logic         i_ce,
    input  logic [6:0]   i_addr,
    input  logic [7:0]   i_wdata,
    input  logic         i_wr,
    input  logic         i_rd,
    output logic [7:0]   o_rdata,
    input  logic         i_encode_clock,
    input  logic         i_prog_sel_strap,
    input  logic         i_mode_strap,
    input  adcfmt_word_t i_sample,
    output logic         o_enc_term_en,
    output logic         o_stab_en,
    output logic         o_locked,
    output logic         o_ka_active,
    output logic         o_internal_clk,
    output logic         o_ddr_mode,
    output logic         o_out_term_en,
    output logic [7:0]   o_drive_current,
    output adcfmt_word_t o_cmos_word,
    output logic         o_output_data_clock_p,
    output logic         o_output_data_clock_n,
    output logic [7:0]   o_lvds_data_pair,
    output logic         o_lvds_ovf,
    output logic         o_lvds_clk
);
    logic         enc_m_q, enc_s_q, enc_d_q;
    logic         par_m_q, par_s_q, mst_m_q, mst_s_q;
    logic [7:0]   clk_cfg_q, out_cfg_q, fmt_cfg_q;
    logic [7:0]   gap_q, period_q, ph_q;
    logic [6:0]   lock_cnt_q;
    logic [5:0]   ka_cnt_q;
    logic         ka_q, base_q;
    adcfmt_lock_t state_q;
    adcfmt_word_t word_q, ddr_word_q;

    // closeness of two periods, one cycle of jitter tolerated
    function automatic logic near(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        d = (a > b) ? a - b : b - a;
        return d <= 8'h01;
    endfunction

    // drive current in 50 uA units, code 0 is the reset default
    function automatic logic [7:0] drv(input logic [2:0] c, input logic dbl);
        logic [7:0] v;
        case (c)
            3'h1: v = 8'h50;
            3'h2: v = 8'h5A;
            3'h4: v = 8'h3C;
            3'h5: v = 8'h32;
            3'h6: v = 8'h2A;
            3'h7: v = 8'h23;
            default: v = 8'h46;
        endcase
        return dbl ? {v[6:0], 1'b0} : v;
    endfunction

    // pick the even or the odd bit of each pair
    function automatic logic [7:0] pick(input logic [15:0] d, input logic odd);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < 8; k++) begin
            r[k] = d[2 * k + (odd ? 1 : 0)];
        end
        return r;
    endfunction

    // pins and straps are asynchronous: two flops before use
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            {enc_m_q, enc_s_q, enc_d_q} <= 3'h0;
            {par_m_q, par_s_q, mst_m_q, mst_s_q} <= 4'h0;
        end else if (i_ce) begin
            enc_m_q <= i_encode_clock;
            enc_s_q <= enc_m_q;
            enc_d_q <= enc_s_q;
            par_m_q <= i_prog_sel_strap;
            par_s_q <= par_m_q;
            mst_m_q <= i_mode_strap;
            mst_s_q <= mst_m_q;
        end
    end

    logic enc_rise;
    logic [7:0] gap_p1;
    assign enc_rise = enc_s_q & ~enc_d_q;
    assign gap_p1   = (gap_q == 8'hFF) ? gap_q : gap_q + 8'h01;

    // parallel mode ignores the serial bits
    logic stab_c, inv_c, ka_off_c, eterm_c, ddr_c, oterm_c, twos_c;
    logic [1:0] phase_c;
    logic [2:0] drv_c;
    assign stab_c   = ~par_s_q & clk_cfg_q[`ADCFMT_STAB_BIT];
    assign inv_c    = ~par_s_q & clk_cfg_q[`ADCFMT_STAB_BIT];
    assign phase_c  = par_s_q ? 2'h0 : clk_cfg_q[`ADCFMT_PHASE_LSB +: 2];
    assign ka_off_c = ~par_s_q & clk_cfg_q[`ADCFMT_KA_OFF_BIT];
    assign eterm_c  = ~par_s_q & clk_cfg_q[`ADCFMT_ETERM_BIT];
    assign ddr_c    = par_s_q ? mst_s_q : out_cfg_q[`ADCFMT_DDR_BIT];
    assign oterm_c  = ~par_s_q & out_cfg_q[`ADCFMT_OTERM_BIT];
    assign drv_c    = par_s_q ? 3'h0 : out_cfg_q[`ADCFMT_DRV_LSB +: 3];
    assign twos_c   = ~par_s_q & fmt_cfg_q[`ADCFMT_TWOS_BIT];

    // register writes; software reset wipes every bit
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            clk_cfg_q <= `ADCFMT_CFG_RESET;
            out_cfg_q <= `ADCFMT_CFG_RESET;
            fmt_cfg_q <= `ADCFMT_CFG_RESET;
        end else if (i_ce && i_wr) begin
            case (i_addr)
                `ADCFMT_REG_RESET: begin
                    if (i_wdata[`ADCFMT_SWRST_BIT]) begin
                        clk_cfg_q <= `ADCFMT_CFG_RESET;
                        out_cfg_q <= `ADCFMT_CFG_RESET;
                        fmt_cfg_q <= `ADCFMT_CFG_RESET;
                    end
                end
                `ADCFMT_REG_CLOCK:  clk_cfg_q <= i_wdata;
                `ADCFMT_REG_OUTPUT: out_cfg_q <= i_wdata;
                `ADCFMT_REG_FORMAT: fmt_cfg_q <= i_wdata;
                default: ;
            endcase
        end
    end

    // read data stand one cycle, reads never touch state
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            o_rdata <= 8'h00;
            if (i_rd) begin
                case (i_addr)
                    `ADCFMT_REG_CLOCK:  o_rdata <= clk_cfg_q;
                    `ADCFMT_REG_OUTPUT: o_rdata <= out_cfg_q;
                    `ADCFMT_REG_FORMAT: o_rdata <= fmt_cfg_q;
                    default:            o_rdata <= 8'h00;
                endcase
            end
        end
    end

    // encode period and phase measured in system cycles
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            gap_q    <= 8'hFF;
            period_q <= 8'h00;
            ph_q     <= 8'hFF;
        end else if (i_ce) begin
            if (enc_rise) begin
                gap_q    <= 8'h00;
                period_q <= gap_p1;
                ph_q     <= 8'h00;
            end else begin
                gap_q <= gap_p1;
                ph_q  <= (ph_q == 8'hFF) ? ph_q : ph_q + 8'h01;
            end
        end
    end

    logic present_c;
    assign present_c = gap_q < 8'(`ADCFMT_LOST_CYC);

    // lock tracker; a period jump restarts acquisition
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q    <= ST_ABSENT;
            lock_cnt_q <= 7'h00;
        end else if (i_ce) begin
            if (!stab_c || !present_c) begin
                state_q    <= ST_ABSENT;
                lock_cnt_q <= 7'h00;
            end else if (enc_rise) begin
                case (state_q)
                    ST_ABSENT: begin
                        state_q    <= ST_ACQUIRE;
                        lock_cnt_q <= 7'h00;
                    end
                    ST_ACQUIRE: begin
                        if (!near(gap_p1, period_q)) begin
                            lock_cnt_q <= 7'h00;
                        end else if (lock_cnt_q == 7'(`ADCFMT_LOCK_EDGES - 1)) begin
                            state_q <= ST_LOCKED;
                        end else begin
                            lock_cnt_q <= lock_cnt_q + 7'h01;
                        end
                    end
                    ST_LOCKED: begin
                        if (!near(gap_p1, period_q)) begin
                            state_q    <= ST_ACQUIRE;
                            lock_cnt_q <= 7'h00;
                        end
                    end
                    default: state_q <= ST_ABSENT;
                endcase
            end
        end
    end

    // keep-alive divider only runs while encode is gone
    logic ka_run;
    assign ka_run = ~present_c & ~ka_off_c;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ka_cnt_q <= 6'h00;
            ka_q     <= 1'b0;
        end else if (i_ce) begin
            if (!ka_run) begin
                ka_cnt_q <= 6'h00;
                ka_q     <= 1'b0;
            end else if (ka_cnt_q == 6'(`ADCFMT_KA_HALF_CYC - 1)) begin
                ka_cnt_q <= 6'h00;
                ka_q     <= ~ka_q;
            end else begin
                ka_cnt_q <= ka_cnt_q + 6'h01;
            end
        end
    end

    // regenerated clock is high for half the measured period
    logic [7:0] half, dly, t;
    logic [9:0] prod;
    logic base_c, shift_c, clk_c, int_c, fall_c, rise_c;
    assign half    = {1'b0, period_q[7:1]};
    assign base_c  = stab_c ? (ph_q < half) : enc_s_q;
    assign prod    = {2'h0, period_q} * {8'h00, phase_c};
    assign dly     = {1'b0, prod[9:3]};
    assign t       = (ph_q >= dly) ? ph_q - dly : ph_q + period_q - dly;
    assign shift_c = stab_c ? (t < half) : base_c;
    assign clk_c   = shift_c ^ inv_c;
    assign int_c   = present_c ? base_c : ka_q;
    assign fall_c  = base_q & ~base_c;
    assign rise_c  = ~base_q & base_c;

    // sample capture; overflow rides in the same word
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            word_q <= '0;
        end else if (i_ce && enc_rise) begin
            word_q.ovf  <= i_sample.ovf;
            word_q.data <= twos_c ? {~i_sample.data[15], i_sample.data[14:0]}
                                  : i_sample.data;
        end
    end

    // control outputs, all registered
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_enc_term_en   <= 1'b0;
            o_stab_en       <= 1'b0;
            o_locked        <= 1'b0;
            o_ka_active     <= 1'b0;
            o_internal_clk  <= 1'b0;
            o_ddr_mode      <= 1'b0;
            o_out_term_en   <= 1'b0;
            o_drive_current <= 8'h46;
        end else if (i_ce) begin
            o_enc_term_en   <= eterm_c;
            o_stab_en       <= stab_c;
            o_locked        <= state_q == ST_LOCKED;
            o_ka_active     <= ka_run;
            o_internal_clk  <= int_c;
            o_ddr_mode      <= ddr_c;
            o_out_term_en   <= oterm_c;
            o_drive_current <= drv(drv_c, oterm_c);
        end
    end

    // data move on base clock edges; clock outputs move alongside
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            base_q                <= 1'b0;
            ddr_word_q            <= '0;
            o_cmos_word           <= '0;
            o_lvds_data_pair      <= 8'h00;
            o_lvds_ovf            <= 1'b0;
            o_lvds_clk            <= 1'b0;
            o_output_data_clock_p <= 1'b0;
            o_output_data_clock_n <= 1'b0;
        end else if (i_ce) begin
            base_q                <= base_c;
            o_lvds_clk            <= ddr_c & clk_c;
            o_output_data_clock_p <= ~ddr_c & clk_c;
            o_output_data_clock_n <= ~ddr_c & ~clk_c;
            if (fall_c) begin
                ddr_word_q       <= word_q;
                o_cmos_word      <= ddr_c ? '0 : word_q;
                o_lvds_data_pair <= ddr_c ? pick(word_q.data, 1'b0) : 8'h00;
                o_lvds_ovf       <= ddr_c & word_q.ovf;
            end else if (rise_c && ddr_c) begin
                o_lvds_data_pair <= pick(ddr_word_q.data, 1'b1);
            end
        end
    end

    default clocking adcfmt_cb @(posedge i_clk); endclocking
    default disable iff (i_reset || !i_ce);

    swrst_clear_a:
    assert property (i_wr && i_addr == `ADCFMT_REG_RESET && i_wdata[`ADCFMT_SWRST_BIT]
        |=> clk_cfg_q == 8'h00 && out_cfg_q == 8'h00 && fmt_cfg_q == 8'h00)
        else $error("software reset left bits set");
    enc_term_a:
    assert property (i_wr && i_addr == `ADCFMT_REG_CLOCK && !par_s_q && !i_rd ##1 !par_s_q
        |=> o_enc_term_en == $past(i_wdata[`ADCFMT_ETERM_BIT], 2))
        else $error("encode termination wrong");
    stab_serial_a:
    assert property ($past(par_s_q) |-> !o_stab_en)
        else $error("stabilizer on in parallel mode");
    lock_gate_a:
    assert property ($rose(o_locked) |-> $past(lock_cnt_q, 2) == 7'(`ADCFMT_LOCK_EDGES - 1))
        else $error("locked too early");
    ka_stop_a:
    assert property (!present_c && ka_off_c |=> !o_ka_active && !ka_q)
        else $error("keep-alive ran while disabled");
    twos_msb_a:
    assert property (enc_rise && twos_c |=> word_q.data[15] == ~$past(i_sample.data[15]))
        else $error("two's complement msb wrong");
    ovf_path_a:
    assert property (enc_rise |=> word_q.ovf == $past(i_sample.ovf))
        else $error("overflow not carried");
    cmos_fall_a:
    assert property ($changed(o_cmos_word) |-> $past(fall_c))
        else $error("cmos data moved off clock fall");
    drive_dbl_a:
    assert property (o_out_term_en |-> o_drive_current == 8'(drv($past(drv_c), 1'b0) << 1))
        else $error("drive current not doubled");

    lock_seen_c: cover property ($rose(o_locked));
    ka_seen_c:   cover property ($rose(o_ka_active) ##[1:200] o_internal_clk);
    ddr_seen_c:  cover property (o_ddr_mode && $changed(o_lvds_data_pair));
endmodule
